// *** src/ecl_pkg.sv ***
// Package for the configuration word loader: word addresses, word and port counts, reset defaults.
// Assumes a 16-bit word-addressed serial configuration memory behind a simple read port.
package ecl_pkg;
  localparam int WORD_W  = 16;
  localparam int ADDR_W  = 8;
  localparam int PORTS   = 3;
  localparam logic [ADDR_W-1:0] ADDR_P1_TUNE = 8'h42;
  localparam logic [ADDR_W-1:0] ADDR_P2_TUNE = 8'h44;
  localparam logic [ADDR_W-1:0] ADDR_PWR0    = 8'h50;
  localparam logic [ADDR_W-1:0] ADDR_DATA0   = 8'h51;
  localparam logic [ADDR_W-1:0] ADDR_PWR1    = 8'h52;
  localparam logic [ADDR_W-1:0] ADDR_DATA1   = 8'h53;
  localparam logic [ADDR_W-1:0] ADDR_PWR2    = 8'h54;
  localparam logic [ADDR_W-1:0] ADDR_DATA2   = 8'h55;
  localparam logic [ADDR_W-1:0] ADDR_SLOT0   = 8'h60;
  localparam logic [ADDR_W-1:0] ADDR_SLOT1   = 8'h62;
  localparam logic [ADDR_W-1:0] ADDR_SLOT2   = 8'h64;
  localparam int NUM_WORDS = 11;
  // Reset defaults of the loaded fields
  localparam logic [4:0]  RST_PHY2     = 5'h00;
  localparam logic [6:0]  RST_PHY3     = 7'h00;
  localparam logic        RST_DEEMPH   = 1'b0;
  localparam logic        RST_COMPL    = 1'b0;
  localparam logic [1:0]  RST_DCNT     = 2'h0;
  localparam logic        RST_NOSOFT   = 1'b0;
  localparam logic [2:0]  RST_AUX      = 3'h0;
  localparam logic        RST_D1D2     = 1'b0;
  localparam logic [1:0]  RST_PME      = 2'h0;
  localparam logic [7:0]  RST_PMDATA   = 8'h00;
  localparam logic        RST_SLOTCLK  = 1'b0;
  localparam logic        RST_DSI      = 1'b0;
  localparam logic        RST_LOW_PRIORITY_VC_COUNT     = 1'b0;
  localparam logic [2:0]  RST_PORTNUM  = 3'h0;
  localparam logic [6:0]  RST_TCMAP    = 7'h00;
endpackage

// *** src/ecl_mem_if.sv ***
// Word read channel between the loader sequencer and the memory reader.
// Assumes one clock; the reader answers each request with one done pulse.
`timescale 1ns/1ps
interface ecl_mem_if;
  logic                         req;
  logic [ecl_pkg::ADDR_W-1:0]   addr;
  logic                         done;
  logic                         present;
  logic [ecl_pkg::WORD_W-1:0]   data;
  modport seq (output req, output addr, input done, input present, input data);
  modport rdr (input req, input addr, output done, output present, output data);
endinterface

// *** src/ecl_word_reader.sv ***
// Memory reader: forwards one word read to the external memory port and registers the answer.
// Assumes the memory answers with memValid, or memAbsent for a word it does not hold.
`timescale 1ns/1ps
module ecl_word_reader (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rstN,
  // Sequencer side
  ecl_mem_if.rdr                 chan,
  // Memory side
  output logic                   memReq,
  output logic [ecl_pkg::ADDR_W-1:0] memAddr,
  input  wire logic              memValid,
  input  wire logic              memAbsent,
  input  wire logic [ecl_pkg::WORD_W-1:0] memData
);
  logic busy_reg;
  logic [ecl_pkg::WORD_W-1:0] data_reg;
  logic present_reg;
  logic done_reg;

  assign memReq = chan.req & ~busy_reg;
  assign memAddr = chan.addr;
  assign chan.done = done_reg;
  assign chan.present = present_reg;
  assign chan.data = data_reg;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      busy_reg <= 1'b0;
      done_reg <= 1'b0;
    end else begin
      done_reg <= 1'b0;
      if (memReq) begin
        busy_reg <= 1'b1;
      end else if (busy_reg && (memValid || memAbsent)) begin
        busy_reg <= 1'b0;
        done_reg <= 1'b1;
      end
    end
  end

  // Answer word is held intact; absent words flag so fields keep defaults
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      data_reg    <= 16'h0000;
      present_reg <= 1'b0;
    end else if (busy_reg && (memValid || memAbsent)) begin
      data_reg    <= memData;
      present_reg <= memValid;
    end
  end
endmodule

// *** src/ecl_loader.sv ***
// Configuration word loader: fetches preload words after reset and updates per-port fields.
// Assumes memValid/memAbsent come from same-clock logic; loadDone gates configuration requests.
`timescale 1ns/1ps
module ecl_loader (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              reset_n,
  // External configuration memory
  output logic                   memReq,
  output logic [7:0]             memAddr,
  input  wire logic              memValid,
  input  wire logic              memAbsent,
  input  wire logic [15:0]       memData,
  // Load status
  output logic                   loadDone,
  // Port 1 and 2 tuning fields
  output logic [1:0]             p1DataCountChangeSelect,
  output logic [4:0]             p2PhyParam2,
  output logic [6:0]             p2PhyParam3,
  output logic                   p2DeemphSelect,
  output logic                   p2ComplianceToDetect,
  output logic [1:0]             p2DataCountChangeSelect,
  // Per-port power fields
  output logic [2:0]             noSoftReset,
  output logic [8:0]             auxCurrent,
  output logic [2:0]             d1Support,
  output logic [2:0]             d2Support,
  output logic [5:0]             pmeSupport,
  output logic [23:0]            pmData,
  // Per-port slot fields
  output logic [2:0]             slotClockConfig,
  output logic [2:0]             devSpecificInit,
  output logic [2:0]             lowPriorityVcCount,
  output logic [8:0]             portNumber,
  output logic [20:0]            tcVc0Map
);
  logic rstMeta_reg;
  logic rstSync_reg;
  logic rstN;

  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rstMeta_reg <= 1'b0;
      rstSync_reg <= 1'b0;
    end else begin
      rstMeta_reg <= 1'b1;
      rstSync_reg <= rstMeta_reg;
    end
  end
  assign rstN = rstSync_reg;

  ecl_mem_if chan ();

  ecl_word_reader reader (
    .clk       (clk),
    .rstN      (rstN),
    .chan      (chan.rdr),
    .memReq    (memReq),
    .memAddr   (memAddr),
    .memValid  (memValid),
    .memAbsent (memAbsent),
    .memData   (memData)
  );

  typedef enum logic [1:0] {SIssue, SWait, SDone} ecl_state_type;
  ecl_state_type state_reg;
  logic [3:0] idx_reg;
  logic [7:0] addrSel;

  // Fetch order; each word is read once
  always_comb begin
    unique case (idx_reg)
      4'h0:    addrSel = ecl_pkg::ADDR_P1_TUNE;
      4'h1:    addrSel = ecl_pkg::ADDR_P2_TUNE;
      4'h2:    addrSel = ecl_pkg::ADDR_PWR0;
      4'h3:    addrSel = ecl_pkg::ADDR_DATA0;
      4'h4:    addrSel = ecl_pkg::ADDR_PWR1;
      4'h5:    addrSel = ecl_pkg::ADDR_DATA1;
      4'h6:    addrSel = ecl_pkg::ADDR_PWR2;
      4'h7:    addrSel = ecl_pkg::ADDR_DATA2;
      4'h8:    addrSel = ecl_pkg::ADDR_SLOT0;
      4'h9:    addrSel = ecl_pkg::ADDR_SLOT1;
      4'hA:    addrSel = ecl_pkg::ADDR_SLOT2;
      default: addrSel = ecl_pkg::ADDR_SLOT2;
    endcase
  end

  // Held low until the synchronised reset lets go, so no read leaves during reset
  assign chan.req = (state_reg == SIssue) && rstN;
  assign chan.addr = addrSel;

  // Sequencer: walks the word list once after reset release
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      state_reg <= SIssue;
      idx_reg   <= 4'h0;
    end else begin
      unique case (state_reg)
        SIssue: state_reg <= SWait;
        SWait: begin
          if (chan.done) begin
            if (idx_reg == 4'(ecl_pkg::NUM_WORDS - 1)) begin
              state_reg <= SDone;
            end else begin
              idx_reg   <= idx_reg + 4'h1;
              state_reg <= SIssue;
            end
          end
        end
        SDone: state_reg <= SDone;
      endcase
    end
  end

  assign loadDone = (state_reg == SDone);

  // Fields update only when the word came back present
  logic take;
  logic [15:0] w;
  assign take = (state_reg == SWait) && chan.done && chan.present;
  assign w = chan.data;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      p1DataCountChangeSelect <= ecl_pkg::RST_DCNT;
    end else if (take && idx_reg == 4'h0) begin
      p1DataCountChangeSelect <= w[15:14];
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      p2PhyParam2             <= ecl_pkg::RST_PHY2;
      p2PhyParam3             <= ecl_pkg::RST_PHY3;
      p2DeemphSelect          <= ecl_pkg::RST_DEEMPH;
      p2ComplianceToDetect    <= ecl_pkg::RST_COMPL;
      p2DataCountChangeSelect <= ecl_pkg::RST_DCNT;
    end else if (take && idx_reg == 4'h1) begin
      p2PhyParam2             <= w[4:0];
      p2PhyParam3             <= w[11:5];
      p2DeemphSelect          <= w[12];
      p2ComplianceToDetect    <= w[13];
      p2DataCountChangeSelect <= w[15:14];
    end
  end

  // Per-port power and slot words, indexed by port
  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      noSoftReset <= {3{ecl_pkg::RST_NOSOFT}};
      auxCurrent  <= {3{ecl_pkg::RST_AUX}};
      d1Support   <= {3{ecl_pkg::RST_D1D2}};
      d2Support   <= {3{ecl_pkg::RST_D1D2}};
      pmeSupport  <= {3{ecl_pkg::RST_PME}};
      pmData      <= {3{ecl_pkg::RST_PMDATA}};
    end else if (take) begin
      for (int p = 0; p < ecl_pkg::PORTS; p++) begin
        if (idx_reg == 4'(2 + 2 * p)) begin
          noSoftReset[p]       <= w[0];
          auxCurrent[3*p +: 3] <= w[3:1];
          d1Support[p]         <= w[4];
          d2Support[p]         <= w[5];
          pmeSupport[2*p +: 2] <= w[7:6];
        end
        if (idx_reg == 4'(3 + 2 * p)) begin
          pmData[8*p +: 8] <= w[15:8];
        end
      end
    end
  end

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      slotClockConfig    <= {3{ecl_pkg::RST_SLOTCLK}};
      devSpecificInit    <= {3{ecl_pkg::RST_DSI}};
      lowPriorityVcCount <= {3{ecl_pkg::RST_LOW_PRIORITY_VC_COUNT}};
      portNumber         <= {3{ecl_pkg::RST_PORTNUM}};
      tcVc0Map           <= {3{ecl_pkg::RST_TCMAP}};
    end else if (take) begin
      for (int p = 0; p < ecl_pkg::PORTS; p++) begin
        if (idx_reg == 4'(8 + p)) begin
          slotClockConfig[p]    <= w[1];
          devSpecificInit[p]    <= w[2];
          lowPriorityVcCount[p] <= w[3];
          portNumber[3*p +: 3]  <= w[6:4];
          tcVc0Map[7*p +: 7]    <= w[15:9];
        end
      end
    end
  end
endmodule

// *** tb/ecl_loader_sva.sv ***
// Port checker for the configuration word loader.
// Assumes it is bound onto ecl_loader; one clock domain.
`timescale 1ns/1ps
module ecl_loader_sva (
  // Clock, reset and memory side
  input wire logic        clk, reset_n, memReq, memValid, memAbsent, loadDone,
  input wire logic [7:0]  memAddr,
  input wire logic [15:0] memData,
  // Loaded fields
  input wire logic [1:0]  p1DataCountChangeSelect, p2DataCountChangeSelect,
  input wire logic [4:0]  p2PhyParam2,
  input wire logic [6:0]  p2PhyParam3,
  input wire logic        p2DeemphSelect, p2ComplianceToDetect,
  input wire logic [2:0]  noSoftReset, d1Support, d2Support, slotClockConfig, devSpecificInit, lowPriorityVcCount,
  input wire logic [8:0]  auxCurrent, portNumber,
  input wire logic [5:0]  pmeSupport,
  input wire logic [23:0] pmData,
  input wire logic [20:0] tcVc0Map
);
  logic [15:0] data1, data2;
  // Word as it stood when the field register lands
  always_ff @(posedge clk) begin
    data1 <= memData;
    data2 <= data1;
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);
  a_req_pulse: assert property (memReq |=> !memReq) else $error("read request held too long");
  a_done_sticky: assert property (loadDone |=> loadDone && !memReq) else $error("done dropped or read after done");
  a_next_read: assert property ((memValid || memAbsent) |-> ##2 (memReq || loadDone)) else $error("no next read");
  a_absent_keep: assert property (memAbsent |=> $stable({pmData, tcVc0Map})[*2]) else $error("absent word changed");
  a_p2_tune: assert property (memValid && memAddr == 8'h44 |-> ##2 {p2DataCountChangeSelect, p2ComplianceToDetect,
    p2DeemphSelect, p2PhyParam3, p2PhyParam2} == data2) else $error("port 2 tuning wrong");
  a_p1_dcnt: assert property (memValid && memAddr == 8'h42 |-> ##2 p1DataCountChangeSelect == data2[15:14])
    else $error("port 1 data count select wrong");
  a_p0_power: assert property (memValid && memAddr == 8'h50 |-> ##2 {pmeSupport[1:0], d2Support[0], d1Support[0],
    auxCurrent[2:0], noSoftReset[0]} == data2[7:0]) else $error("port 0 power word wrong");
  a_p1_pmdata: assert property (memValid && memAddr == 8'h53 |-> ##2 pmData[15:8] == data2[15:8])
    else $error("port 1 power data wrong");
  a_p0_slot: assert property (memValid && memAddr == 8'h60 |-> ##2 {portNumber[2:0], lowPriorityVcCount[0],
    devSpecificInit[0], slotClockConfig[0]} == data2[6:1]) else $error("port 0 slot word wrong");
  a_p2_tcmap: assert property (memValid && memAddr == 8'h64 |-> ##2 tcVc0Map[20:14] == data2[15:9])
    else $error("port 2 traffic class map wrong");
  c_absent: cover property (memAbsent);
  c_done: cover property ($rose(loadDone));
  c_slow: cover property (memReq ##1 !memValid [*4] ##1 memValid);
endmodule

// *** tb/ecl_mem_model.sv ***
// Configuration memory model answering one word per read request.
// Assumes the bench fills img, gone and lat before a load.
`timescale 1ns/1ps
module ecl_mem_model (
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       reset_n,
  // Loader side
  input  wire logic       memReq,
  input  wire logic [7:0] memAddr,
  output logic            memValid,
  output logic            memAbsent,
  output logic [15:0]     memData
);
  logic [15:0] img [256];
  logic        gone [256];
  int          lat, cnt;
  logic        busy;
  logic [7:0]  addr;
  always @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      busy <= 1'b0;
      memValid <= 1'b0;
      memAbsent <= 1'b0;
      memData <= 16'h0000;
    end else begin
      memValid <= 1'b0;
      memAbsent <= 1'b0;
      // Idle data toggles each cycle so a word taken one cycle late never passes as fresh
      memData <= ~memData;
      if (memReq && !busy) begin
        busy <= 1'b1;
        addr <= memAddr;
        cnt <= lat;
      end else if (busy && cnt != 0) begin
        cnt <= cnt - 1;
      end else if (busy) begin
        busy <= 1'b0;
        memValid <= !gone[addr];
        memAbsent <= gone[addr];
        if (!gone[addr]) memData <= img[addr];
      end
    end
  end
endmodule

// *** tb/tb.sv ***
// Self-checking bench for the configuration word loader.
// Assumes the package, interface and design files are compiled first.
`timescale 1ns/1ps
`define CHK(got, exp) begin comparisons++; if ((got) !== (exp)) begin errTotal++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp); end end
module tb;
  logic        clk, reset_n, memReq, memValid, memAbsent, loadDone, p2DeemphSelect, p2ComplianceToDetect;
  logic [7:0]  memAddr;
  logic [15:0] memData;
  logic [1:0]  p1DataCountChangeSelect, p2DataCountChangeSelect;
  logic [4:0]  p2PhyParam2;
  logic [6:0]  p2PhyParam3;
  logic [2:0]  noSoftReset, d1Support, d2Support, slotClockConfig, devSpecificInit, lowPriorityVcCount;
  logic [8:0]  auxCurrent, portNumber;
  logic [5:0]  pmeSupport;
  logic [23:0] pmData;
  logic [20:0] tcVc0Map;
  int          errTotal, comparisons;
  ecl_loader i_dut (.clk, .reset_n, .memReq, .memAddr, .memValid, .memAbsent, .memData, .loadDone,
    .p1DataCountChangeSelect, .p2PhyParam2, .p2PhyParam3, .p2DeemphSelect, .p2ComplianceToDetect,
    .p2DataCountChangeSelect, .noSoftReset, .auxCurrent, .d1Support, .d2Support, .pmeSupport, .pmData,
    .slotClockConfig, .devSpecificInit, .lowPriorityVcCount, .portNumber, .tcVc0Map);
  ecl_mem_model i_mem (.clk, .reset_n, .memReq, .memAddr, .memValid, .memAbsent, .memData);
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  function automatic logic [15:0] w(input int a);
    return i_mem.gone[a] ? 16'h0000 : i_mem.img[a];
  endfunction
  task automatic fill(input logic [15:0] seed, input int latency);
    for (int a = 0; a < 256; a++) begin
      i_mem.img[a] = seed ^ (a[15:0] * 16'h1357);
      i_mem.gone[a] = 1'b0;
    end
    i_mem.lat = latency;
  endtask
  task automatic wait_done();
    for (int i = 0; i < 3000 && loadDone !== 1'b1; i++) @(posedge clk);
    #1;
  endtask
  task automatic check_all();
    logic [15:0] t, pw, dw, sw;
    `CHK(loadDone, 1'b1)
    t = w('h42);
    `CHK(p1DataCountChangeSelect, t[15:14])
    t = w('h44);
    `CHK({p2DataCountChangeSelect, p2ComplianceToDetect, p2DeemphSelect, p2PhyParam3, p2PhyParam2}, t)
    for (int p = 0; p < 3; p++) begin
      pw = w('h50 + 2 * p);
      dw = w('h51 + 2 * p);
      sw = w('h60 + 2 * p);
      `CHK({pmeSupport[2*p+:2], d2Support[p], d1Support[p], auxCurrent[3*p+:3], noSoftReset[p]}, pw[7:0])
      `CHK(pmData[8*p+:8], dw[15:8])
      `CHK({tcVc0Map[7*p+:7], portNumber[3*p+:3], lowPriorityVcCount[p], devSpecificInit[p], slotClockConfig[p]},
        {sw[15:9], sw[6:1]})
    end
  endtask
  task automatic test_done();
    $display("comparisons=%0d errTotal=%0d", comparisons, errTotal);
    if (errTotal == 0 && comparisons > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    #500000;
    errTotal++;
    test_done();
  end
  initial begin
    reset_n = 1'b0;
    fill(16'hA5C3, 0);
    repeat (3) @(posedge clk);
    reset_n <= 1'b1;
    wait_done();
    check_all();
    // Slow memory, two absent words, then a reset in mid-load
    @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    #1;
    fill(16'h3C96, 3);
    i_mem.gone['h51] = 1'b1;
    i_mem.gone['h62] = 1'b1;
    `CHK({memReq, loadDone, pmData, tcVc0Map}, 47'h0)
    @(posedge clk);
    reset_n <= 1'b1;
    repeat (14) @(posedge clk);
    reset_n <= 1'b0;
    @(posedge clk);
    reset_n <= 1'b1;
    wait_done();
    check_all();
    test_done();
  end
endmodule
bind ecl_loader ecl_loader_sva i_sva (.clk, .reset_n, .memReq, .memAddr, .memValid, .memAbsent, .memData,
  .loadDone, .p1DataCountChangeSelect, .p2PhyParam2, .p2PhyParam3, .p2DeemphSelect, .p2ComplianceToDetect,
  .p2DataCountChangeSelect, .noSoftReset, .auxCurrent, .d1Support, .d2Support, .pmeSupport, .pmData,
  .slotClockConfig, .devSpecificInit, .lowPriorityVcCount, .portNumber, .tcVc0Map);
